// ==== logic/l1dp_params.svh ====
// Constants for the level-1 data protection lock and fault block
`ifndef L1DP_PARAMS_SVH
`define L1DP_PARAMS_SVH

// Register byte addresses
`define L1DP_A_FAULT_ADDR   32'h0184AC00
`define L1DP_A_FAULT_REC    32'h0184AC04
`define L1DP_A_FAULT_CLR    32'h0184AC08
`define L1DP_A_KEY0         32'h0184AD00
`define L1DP_A_KEY1         32'h0184AD04
`define L1DP_A_KEY2         32'h0184AD08
`define L1DP_A_KEY3         32'h0184AD0C
`define L1DP_A_LOCK_CMD     32'h0184AD10
`define L1DP_A_LOCK_STATE   32'h0184AD14
`define L1DP_A_PAGE_BASE    32'h0184AE00
`define L1DP_A_PAGE_LAST    32'h0184AE7C

// Page attribute entry layout
`define L1DP_PAGE_RESET     16'hFFF6
`define L1DP_PAGE_WMASK     16'hFF36
`define L1DP_PAGE_FIXED     16'h00C0
`define L1DP_PAGE_W         16

// Lock command bits
`define L1DP_CMD_UNLOCK     0
`define L1DP_CMD_LOCK       1
`define L1DP_CMD_KEY_RESET  2

// Fault record fields
`define L1DP_FR_ID_HI       15
`define L1DP_FR_ID_LO       9
`define L1DP_FR_LOCAL       8
`define L1DP_FR_SUP_RD      5
`define L1DP_FR_SUP_WR      4
`define L1DP_FR_USR_RD      2
`define L1DP_FR_USR_WR      1
`define L1DP_FR_ID_W        7

`define L1DP_FAULT_ERASE    0
`define L1DP_LOCK_BIT       0
`define L1DP_PROT_SUP       0
`define L1DP_IDX_HI         6
`define L1DP_IDX_LO         2

`endif

// ==== logic/l1dp_pkg.sv ====
// Types shared by the level-1 data protection block
package l1dp_pkg;

    typedef enum logic [3:0] {
        L1DP_SEL_NONE  = 4'h0,
        L1DP_SEL_FADDR = 4'h1,
        L1DP_SEL_FREC  = 4'h2,
        L1DP_SEL_FCLR  = 4'h3,
        L1DP_SEL_KEY0  = 4'h4,
        L1DP_SEL_KEY1  = 4'h5,
        L1DP_SEL_KEY2  = 4'h6,
        L1DP_SEL_KEY3  = 4'h7,
        L1DP_SEL_CMD   = 4'h8,
        L1DP_SEL_STATE = 4'h9,
        L1DP_SEL_PAGE  = 4'hA
    } l1dp_sel_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [6:0]  id;
        logic        local_acc;
        logic        sup;
        logic        wr;
    } l1dp_fault_s;

endpackage

// ==== logic/l1dp_top.sv ====
// APB register block: page attributes, 64-bit key lock, fault capture
//
// The placing of the registers and register access over APB were chosen for this implementation.
`include "l1dp_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Execute bits of every page entry read zero and ignore writes.
// - Page entries reset to all IDs, local, bits 7:6 set, read/write.
// - A 64-bit key lock decides whether protection entries may be written.
// - Key word 0 gives bits 31:0, word 1 bits 63:32; write-only.
// - Writes to key words 2 and 3 are discarded without effect.
// - Command bit 1 engages lock if sequence correct; bit 2 resets status.
// - Command bit 0 disengages lock if correct; zero writes do nothing.
// - Lock state bit 0 shows engaged lock, resets zero, rest zero.
// - A protection violation is captured in dedicated fault registers.
// - Fault address register holds the full 32-bit faulting address.
// - Fault bits 15:9 hold requestor ID bits 6:0, zero-extended.
// - Fault bit 8 marks a local access; ID field then reads zero.
// - Fault bit 5 marks supervisor read, bit 4 supervisor write.
// - Bit 2 user read, bit 1 user write; other bits read zero.
// - Writing one to fault clear bit 0 erases the fault record.
// - Only the first fault is held and signalled until cleared.
// - Fault clear ignores bits 31:1.
// - All may read except key words; only supervisor may write.
// - While locked, page attribute entries cannot be updated.
module l1dp_top #(
    parameter int NPAGE = 32,
    parameter int ID_W  = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    input  wire logic [2:0]        pprot,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              fault_valid,
    input  wire logic [31:0]       fault_addr,
    input  wire logic [ID_W-1:0]   fault_id,
    input  wire logic              fault_local,
    input  wire logic              fault_sup,
    input  wire logic              fault_write,
    output logic                   fault_exc,
    input  wire logic [4:0]        chk_page,
    output logic [15:0]            chk_attr,
    output logic                   lock_engaged
);

    //--------------------------------------------------------------
    // Parameter checks
    //--------------------------------------------------------------
    generate
        if (NPAGE < 1 || NPAGE > 32) begin : g_bad_npage
            $error("NPAGE must lie in 1..32");
        end
        if (ID_W < 1) begin : g_bad_idw
            $error("ID_W must be at least 1");
        end
    endgenerate

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    logic [15:0]          page_r [NPAGE];
    logic [63:0]          key_pend_r;
    logic [63:0]          key_lock_r;
    logic [1:0]           key_seen_r;
    logic                 lock_r;
    logic                 fault_held_r;
    l1dp_pkg::l1dp_fault_s fault_r;
    logic                 fault_exc_r;
    logic [15:0]          chk_attr_r;
    logic                 pready_r;
    logic [31:0]          prdata_r;
    logic                 pslverr_r;
    logic                 err_nxt;
    logic [31:0]          rdata_nxt;
    l1dp_pkg::l1dp_sel_e  sel;
    logic [4:0]           page_idx;
    logic                 sup_acc;
    logic                 wr_go;
    logic [31:0]          frec_word;
    logic [6:0]           id_ext;
    logic                 page_go;
    logic                 key0_go;
    logic                 key1_go;
    logic                 cmd_go;
    logic                 erase_go;
    logic                 fault_take;

    assign pready       = pready_r;
    assign prdata       = prdata_r;
    assign pslverr      = pslverr_r;
    assign fault_exc    = fault_exc_r;
    assign chk_attr     = chk_attr_r;
    assign lock_engaged = lock_r;

    //--------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------
    always_comb begin
        sel = l1dp_pkg::L1DP_SEL_NONE;
        if (paddr == `L1DP_A_FAULT_ADDR) begin
            sel = l1dp_pkg::L1DP_SEL_FADDR;
        end else if (paddr == `L1DP_A_FAULT_REC) begin
            sel = l1dp_pkg::L1DP_SEL_FREC;
        end else if (paddr == `L1DP_A_FAULT_CLR) begin
            sel = l1dp_pkg::L1DP_SEL_FCLR;
        end else if (paddr == `L1DP_A_KEY0) begin
            sel = l1dp_pkg::L1DP_SEL_KEY0;
        end else if (paddr == `L1DP_A_KEY1) begin
            sel = l1dp_pkg::L1DP_SEL_KEY1;
        end else if (paddr == `L1DP_A_KEY2) begin
            sel = l1dp_pkg::L1DP_SEL_KEY2;
        end else if (paddr == `L1DP_A_KEY3) begin
            sel = l1dp_pkg::L1DP_SEL_KEY3;
        end else if (paddr == `L1DP_A_LOCK_CMD) begin
            sel = l1dp_pkg::L1DP_SEL_CMD;
        end else if (paddr == `L1DP_A_LOCK_STATE) begin
            sel = l1dp_pkg::L1DP_SEL_STATE;
        end else if (paddr >= `L1DP_A_PAGE_BASE &&
                     paddr <= `L1DP_A_PAGE_LAST &&
                     paddr[1:0] == 2'h0 &&
                     32'(page_idx) < NPAGE) begin
            sel = l1dp_pkg::L1DP_SEL_PAGE;
        end
    end

    assign page_idx = paddr[`L1DP_IDX_HI:`L1DP_IDX_LO];
    assign sup_acc  = pprot[`L1DP_PROT_SUP];

    //--------------------------------------------------------------
    // Fault record word
    //--------------------------------------------------------------
    // ID is zero-extended or cut to seven bits
    generate
        if (ID_W >= `L1DP_FR_ID_W) begin : g_id_cut
            assign id_ext = fault_id[6:0];
        end else begin : g_id_ext
            assign id_ext = {{(`L1DP_FR_ID_W-ID_W){1'b0}}, fault_id};
        end
    endgenerate

    always_comb begin
        frec_word = 32'h00000000;
        frec_word[`L1DP_FR_ID_HI:`L1DP_FR_ID_LO] = fault_r.id;
        frec_word[`L1DP_FR_LOCAL] = fault_r.local_acc;
        frec_word[`L1DP_FR_SUP_RD] = fault_r.sup & ~fault_r.wr;
        frec_word[`L1DP_FR_SUP_WR] = fault_r.sup & fault_r.wr;
        frec_word[`L1DP_FR_USR_RD] = ~fault_r.sup & ~fault_r.wr;
        frec_word[`L1DP_FR_USR_WR] = ~fault_r.sup & fault_r.wr;
        if (!fault_held_r) begin
            frec_word = 32'h00000000;
        end
    end

    //--------------------------------------------------------------
    // Read data and error for the access phase
    //--------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        if (pwrite) begin
            if (!sup_acc) begin
                err_nxt = 1'b1;
            end else if (sel == l1dp_pkg::L1DP_SEL_NONE ||
                         sel == l1dp_pkg::L1DP_SEL_FADDR ||
                         sel == l1dp_pkg::L1DP_SEL_FREC ||
                         sel == l1dp_pkg::L1DP_SEL_STATE) begin
                err_nxt = 1'b1;
            end else if (sel == l1dp_pkg::L1DP_SEL_PAGE && lock_r) begin
                err_nxt = 1'b1;
            end
        end else begin
            case (sel)
                l1dp_pkg::L1DP_SEL_FADDR: begin
                    rdata_nxt = fault_r.addr;
                end
                l1dp_pkg::L1DP_SEL_FREC: begin
                    rdata_nxt = frec_word;
                end
                l1dp_pkg::L1DP_SEL_STATE: begin
                    rdata_nxt[`L1DP_LOCK_BIT] = lock_r;
                end
                l1dp_pkg::L1DP_SEL_PAGE: begin
                    rdata_nxt = {16'h0000, page_r[page_idx]};
                end
                l1dp_pkg::L1DP_SEL_FCLR,
                l1dp_pkg::L1DP_SEL_CMD: begin
                    rdata_nxt = 32'h00000000;
                end
                l1dp_pkg::L1DP_SEL_KEY0,
                l1dp_pkg::L1DP_SEL_KEY1,
                l1dp_pkg::L1DP_SEL_KEY2,
                l1dp_pkg::L1DP_SEL_KEY3: begin
                    err_nxt = 1'b1;
                end
                default: begin
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // APB handshake: one access-phase cycle
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel & ~penable & ~pready_r;
            if (psel && !penable) begin
                prdata_r  <= pwrite ? 32'h00000000 : rdata_nxt;
                pslverr_r <= err_nxt;
            end else begin
                prdata_r  <= 32'h00000000;
                pslverr_r <= 1'b0;
            end
        end
    end

    // Write commits at the completing edge only
    assign wr_go = psel & penable & pready_r & pwrite & ~pslverr_r &
                   (pstrb == 4'hF);

    //--------------------------------------------------------------
    // Per-register write strobes
    //--------------------------------------------------------------
    assign page_go  = wr_go && sel == l1dp_pkg::L1DP_SEL_PAGE;
    assign key0_go  = wr_go && sel == l1dp_pkg::L1DP_SEL_KEY0;
    assign key1_go  = wr_go && sel == l1dp_pkg::L1DP_SEL_KEY1;
    assign cmd_go   = wr_go && sel == l1dp_pkg::L1DP_SEL_CMD;
    // only bit 0 of the clear word counts
    assign erase_go = wr_go && sel == l1dp_pkg::L1DP_SEL_FCLR &&
                      pwdata[`L1DP_FAULT_ERASE];
    // a fault in the erase cycle is kept, so none goes unseen
    assign fault_take = fault_valid && (!fault_held_r || erase_go);

    //--------------------------------------------------------------
    // Page attribute entries
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPAGE; i++) begin
                page_r[i] <= `L1DP_PAGE_RESET;
            end
        end else if (page_go && !lock_r) begin
            page_r[page_idx] <= (pwdata[15:0] & `L1DP_PAGE_WMASK) |
                                `L1DP_PAGE_FIXED;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_attr_r <= 16'h0000;
        end else if (32'(chk_page) < NPAGE) begin
            chk_attr_r <= page_r[chk_page];
        end else begin
            chk_attr_r <= 16'h0000;
        end
    end

    //--------------------------------------------------------------
    // Key lock
    //--------------------------------------------------------------
    // 64-bit key lock
    // words 2 and 3 discarded
    // Key words stay writable while locked so unlock can be keyed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_pend_r <= 64'h0000000000000000;
            key_seen_r <= 2'h0;
        end else if (key0_go) begin
            key_pend_r[31:0] <= pwdata;
            key_seen_r[0]    <= 1'b1;
        end else if (key1_go) begin
            key_pend_r[63:32] <= pwdata;
            key_seen_r[1]     <= 1'b1;
        end else if (cmd_go &&
                     (pwdata[`L1DP_CMD_KEY_RESET] ||
                      pwdata[`L1DP_CMD_LOCK] ||
                      pwdata[`L1DP_CMD_UNLOCK])) begin
            // key status reset; any command with bit 0, 1 or 2 set ends a sequence
            key_pend_r <= 64'h0000000000000000;
            key_seen_r <= 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r     <= 1'b0;
            key_lock_r <= 64'h0000000000000000;
        end else if (cmd_go &&
                     !pwdata[`L1DP_CMD_KEY_RESET]) begin
            if (pwdata[`L1DP_CMD_LOCK] && !pwdata[`L1DP_CMD_UNLOCK]) begin
                // lock needs a full key first
                // Lock while locked is ignored; the stored key stays
                if (!lock_r && key_seen_r == 2'h3) begin
                    lock_r     <= 1'b1;
                    key_lock_r <= key_pend_r;
                end
            end else if (pwdata[`L1DP_CMD_UNLOCK] &&
                         !pwdata[`L1DP_CMD_LOCK]) begin
                if (lock_r && key_seen_r == 2'h3 &&
                    key_pend_r == key_lock_r) begin
                    lock_r <= 1'b0;
                end
            end
        end
    end

    //--------------------------------------------------------------
    // Fault capture
    //--------------------------------------------------------------
    // capture on violation
    // first fault only; new fault wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_held_r <= 1'b0;
            fault_r      <= '0;
        end else begin
            if (fault_take) begin
                fault_held_r      <= 1'b1;
                fault_r.addr      <= fault_addr;
                fault_r.id        <= fault_local ? 7'h00 : id_ext;
                fault_r.local_acc <= fault_local;
                fault_r.sup       <= fault_sup;
                fault_r.wr        <= fault_write;
            end else if (erase_go) begin
                fault_held_r <= 1'b0;
                fault_r      <= '0;
            end
        end
    end

    // exception pulse for the captured fault only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_exc_r <= 1'b0;
        end else begin
            fault_exc_r <= fault_take;
        end
    end

endmodule

`default_nettype wire

// ==== tb/l1dp_assertions.sv ====
// Checker for bus refusals, lock state and fault capture
`timescale 1ns/1ps
`default_nettype none
`include "l1dp_params.svh"
module l1dp_assertions #(
    parameter int NPAGE = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [2:0]  pprot,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    input  wire logic        fault_valid,
    input  wire logic        fault_exc,
    input  wire logic [4:0]  chk_page,
    input  wire logic [15:0] chk_attr,
    input  wire logic        lock_engaged
);
    logic held_r;
    logic setup;
    logic done;
    logic clr_now;
    logic cmd_done;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign setup = psel && !penable;
    assign done = psel && penable && pready && pwrite;
    assign clr_now = done && pprot[0] && pstrb == 4'hF && pwdata[0]
        && paddr == `L1DP_A_FAULT_CLR;
    assign cmd_done = done && paddr == `L1DP_A_LOCK_CMD;
    // ---------------------------------------------
    // Fault held since the last erase
    // ---------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_r <= 1'b0;
        end else if (fault_valid) begin
            held_r <= 1'b1;
        end else if (clr_now) begin
            held_r <= 1'b0;
        end
    end
    sequence s_refused;
        pready && pslverr;
    endsequence
    sequence s_capture;
        fault_valid && (!held_r || clr_now);
    endsequence
    a_exec_zero: assert property (chk_attr[3] == 1'b0 && !chk_attr[0])
        else $error("execute bit seen set");
    a_fixed_ones: assert property (int'(chk_page) < NPAGE
        |=> chk_attr[7:6] == 2'b11) else $error("bits 7:6 not ones");
    a_user_write: assert property (setup && pwrite && !pprot[0]
        |=> s_refused) else $error("user write not refused");
    a_key_read: assert property (setup && !pwrite
        && paddr >= `L1DP_A_KEY0 && paddr <= `L1DP_A_KEY3 |=> s_refused)
        else $error("key word read not refused");
    a_page_locked: assert property (setup && pwrite && lock_engaged
        && paddr >= `L1DP_A_PAGE_BASE && paddr <= `L1DP_A_PAGE_LAST
        |=> s_refused) else $error("page write while locked");
    a_state_read: assert property (setup && !pwrite
        && paddr == `L1DP_A_LOCK_STATE
        |=> pready && prdata == {31'h0, $past(lock_engaged)})
        else $error("lock state read wrong");
    a_lock_cause: assert property ($changed(lock_engaged)
        |-> $past(cmd_done))
        else $error("lock changed without command");
    a_first_fault: assert property (s_capture
        |=> fault_exc ##1 !fault_exc) else $error("fault pulse wrong");
    a_later_quiet: assert property (fault_valid && held_r && !clr_now
        |=> !fault_exc) else $error("pulse for a later fault");
    a_exc_cause: assert property (fault_exc |-> $past(fault_valid))
        else $error("pulse without fault");
endmodule
bind l1dp_top l1dp_assertions #(.NPAGE(NPAGE)) chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot, .pready,
    .prdata, .pslverr, .fault_valid, .fault_exc, .chk_page, .chk_attr,
    .lock_engaged);
`default_nettype wire

// ==== tb/l1dp_requestor.sv ====
// Model of the masters that report protection violations
`timescale 1ns/1ps
`default_nettype none
module l1dp_requestor #(
    parameter int ID_W = 8
) (
    input  wire logic            pclk,
    output logic                 fault_valid,
    output logic [31:0]          fault_addr,
    output logic [ID_W-1:0]      fault_id,
    output logic                 fault_local,
    output logic                 fault_sup,
    output logic                 fault_write
);
    initial begin
        fault_valid = 1'b0;
        {fault_addr, fault_id} = '0;
        {fault_local, fault_sup, fault_write} = 3'h0;
    end
    // one-cycle report; qualifiers turn to junk after it
    task automatic raise(input logic [31:0] a, input logic [ID_W-1:0] id,
                         input logic [2:0] lsw);
        @(posedge pclk);
        fault_valid <= 1'b1;
        {fault_addr, fault_id} <= {a, id};
        {fault_local, fault_sup, fault_write} <= lsw;
        @(posedge pclk);
        fault_valid <= 1'b0;
        {fault_addr, fault_id} <= ~{a, id};
        {fault_local, fault_sup, fault_write} <= ~lsw;
    endtask
endmodule
`default_nettype wire

// ==== tb/l1_data_protection_lock_fault_bench.sv ====
// Self-checking bench for the protection lock and fault block
`timescale 1ns/1ps
`default_nettype none
`include "l1dp_params.svh"
module l1_data_protection_lock_fault_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, fault_addr, rd;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
    logic        fault_valid, fault_local, fault_sup, fault_write;
    logic        fault_exc, lock_engaged;
    logic [7:0]  fault_id;
    logic [4:0]  chk_page;
    logic [15:0] chk_attr;
    int          error_cnt;
    int          n_compared;
    l1dp_top #(.NPAGE(32), .ID_W(8)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .pprot, .pready, .prdata, .pslverr,
        .fault_valid, .fault_addr, .fault_id, .fault_local, .fault_sup,
        .fault_write, .fault_exc, .chk_page, .chk_attr, .lock_engaged);
    l1dp_requestor #(.ID_W(8)) req (.pclk, .fault_valid, .fault_addr,
        .fault_id, .fault_local, .fault_sup, .fault_write);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [31:0] a, d,
                       input logic sup, input logic ee);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= {2'b00, sup};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, d, input logic ee);
        acc(1'b1, a, d, 1'b1, ee);
    endtask
    task automatic rdc(input logic [31:0] a, e, input string nm);
        acc(1'b0, a, 32'h0, 1'b1, 1'b0);
        chk(nm, e, rd);
    endtask
    task automatic key(input logic [63:0] k);
        wr(`L1DP_A_KEY0, k[31:0], 1'b0);
        wr(`L1DP_A_KEY1, k[63:32], 1'b0);
    endtask
    task automatic lk(input logic [31:0] c, input logic e);
        wr(`L1DP_A_LOCK_CMD, c, 1'b0);
        chk("lock_engaged", {31'h0, e}, {31'h0, lock_engaged});
    endtask
    task automatic exc(input logic e);
        @(negedge pclk);
        chk("fault_exc", {31'h0, e}, {31'h0, fault_exc});
        @(posedge pclk);
    endtask
    function automatic logic [31:0] fsr(input logic [7:0] id,
                                        input logic l, s, w);
        return {16'h0, l ? 7'h0 : id[6:0], l, 2'b00, s & !w, s & w, 1'b0,
                !s & !w, !s & w, 1'b0};
    endfunction
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset();
        rdc(`L1DP_A_LOCK_STATE, 32'h0, "lock_state");
        rdc(`L1DP_A_PAGE_BASE, 32'h0000FFF6, "page0");
        rdc(`L1DP_A_PAGE_LAST, 32'h0000FFF6, "page31");
        chk("chk_attr", 32'h0000FFF6, {16'h0, chk_attr});
        acc(1'b0, 32'h0184AF00, 32'h0, 1'b1, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_page();
        wr(`L1DP_A_PAGE_BASE + 32'hC, 32'hFFFFFFFF, 1'b0);
        rdc(`L1DP_A_PAGE_BASE + 32'hC, 32'h0000FFF6, "page3");
        wr(`L1DP_A_PAGE_BASE + 32'hC, 32'h00000009, 1'b0);
        acc(1'b1, `L1DP_A_PAGE_BASE + 32'hC, 32'hFF00, 1'b0, 1'b1);
        acc(1'b0, `L1DP_A_PAGE_BASE + 32'hC, 32'h0, 1'b0, 1'b0);
        chk("page3", 32'h000000C0, rd);
        chk_page <= 5'd3;
        @(posedge pclk);
        @(negedge pclk);
        chk("chk_attr", 32'h000000C0, {16'h0, chk_attr});
        @(posedge pclk);
        $display("test page done");
    endtask
    task automatic t_lock();
        key(64'h0123456789ABCDEF);
        wr(`L1DP_A_KEY2, 32'h5A5A5A5A, 1'b0);
        lk(32'h2, 1'b1);
        rdc(`L1DP_A_LOCK_STATE, 32'h1, "lock_state");
        wr(`L1DP_A_PAGE_BASE, 32'h0, 1'b1);
        rdc(`L1DP_A_PAGE_BASE, 32'h0000FFF6, "page0");
        acc(1'b0, `L1DP_A_KEY1, 32'h0, 1'b1, 1'b1);
        key(64'h1123456789ABCDEF);
        lk(32'h1, 1'b1);
        wr(`L1DP_A_KEY0, 32'h89ABCDEF, 1'b0);
        lk(32'h1, 1'b1);
        key(64'h0123456789ABCDEF);
        lk(32'h0, 1'b1);
        wr(`L1DP_A_KEY3, 32'hFFFFFFFF, 1'b0);
        lk(32'h4, 1'b1);
        lk(32'h1, 1'b1);
        key(64'h0123456789ABCDEF);
        acc(1'b1, `L1DP_A_LOCK_CMD, 32'h1, 1'b0, 1'b1);
        lk(32'h1, 1'b0);
        wr(`L1DP_A_PAGE_BASE, 32'h0, 1'b0);
        $display("test lock done");
    endtask
    task automatic t_fault();
        req.raise(32'h80001234, 8'hA5, 3'b010);
        exc(1'b1);
        rdc(`L1DP_A_FAULT_ADDR, 32'h80001234, "fault_addr");
        rdc(`L1DP_A_FAULT_REC, fsr(8'hA5, 0, 1, 0), "fault_rec");
        req.raise(32'h00000040, 8'h01, 3'b001);
        exc(1'b0);
        wr(`L1DP_A_FAULT_CLR, 32'hFFFFFFFE, 1'b0);
        rdc(`L1DP_A_FAULT_ADDR, 32'h80001234, "fault_addr");
        for (int i = 0; i < 4; i++) begin
            wr(`L1DP_A_FAULT_CLR, 32'h1, 1'b0);
            rdc(`L1DP_A_FAULT_ADDR, 32'h0, "fault_addr");
            rdc(`L1DP_A_FAULT_REC, 32'h0, "fault_rec");
            req.raise(32'hFFFF0000 >> i, 8'h80 | i, {i == 2, 2'(i)});
            exc(1'b1);
            rdc(`L1DP_A_FAULT_ADDR, 32'hFFFF0000 >> i, "fault_addr");
            rdc(`L1DP_A_FAULT_REC, fsr(8'h80 | i, i == 2, i[1], i[0]),
                "fault_rec");
        end
        $display("test fault done");
    endtask
    initial begin
        error_cnt = 0;
        n_compared = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
        pstrb = 4'hF;
        chk_page = 5'd5;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_page();
        t_lock();
        t_fault();
        final_report();
    end
endmodule
`default_nettype wire
